// ==== hdl/tsd_top.sv ====
// Tile security word, OTP loader and programming gate, JTAG chain
// and shared debug pin control.
// Assumes an external OTP array with a one-request read port, an SRAM
// write port, and JTAG pins clocked by tck, unrelated to sys_clk.
`default_nettype none
`include "tsd_defs.svh"

module tsd_top
   import tsd_pkg::*;
#(
   // Identification values are arbitrary
   parameter logic [31:0] CHIP_JTAG_IDENTIFICATION_WORD = 32'h0123_4001,
   parameter logic [31:0] BSCAN_JTAG_IDENTIFICATION_WORD = 32'h0123_5001,
   parameter logic [`TSD_REV_W-1:0] SILICON_REV = 18'h0_0001
)(
   // System
   input wire logic sys_clk,
   input wire logic sys_rst,
   // OTP read and write
   output logic otp_rd_en,
   output logic [`TSD_OTP_AW-1:0] otp_rd_addr,
   input wire logic otp_rd_valid,
   input wire logic [31:0] otp_rd_data,
   output logic otp_wr_en,
   output logic [`TSD_OTP_AW-1:0] otp_wr_addr,
   output logic [31:0] otp_wr_data,
   output logic otp_redundant_en,
   // SRAM fill and boot
   output logic sram_we,
   output logic [`TSD_OTP_AW-1:0] sram_addr,
   output logic [31:0] sram_wdata,
   output logic boot_go,
   output logic boot_from_otp,
   // Programming resource ports
   input wire logic res_wr,
   input wire logic [`TSD_ID_W-1:0] res_id,
   input wire logic [31:0] res_data,
   output logic prog_done,
   output logic prog_reject,
   // Security word
   output logic [31:0] security_word,
   output logic security_loaded,
   output logic [`TSD_SEC_SW_HI-`TSD_SEC_SW_LO:0] sw_field,
   // Switch link access
   input wire logic link_req,
   output logic link_grant,
   // Tile debug access from JTAG
   output logic tile_req,
   output logic [31:0] tile_data,
   // Debug sync pin
   input wire logic dbg_out_mode,
   input wire logic dbg_in_mode,
   input wire logic bp_hit,
   input wire logic dbg_resume,
   input wire logic debug_n_i,
   output logic debug_n_o,
   output logic debug_n_oe,
   output logic dbg_enter,
   // JTAG
   input wire logic tck,
   input wire logic trst_n,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo
);
   tsd_sys_s r;
   tsd_sys_s n;
   tsd_jtg_s jr;
   tsd_jtg_s jn;
   logic pend;
   logic go;
   logic bad;
   logic tosec;
   logic [3:0] locks;
   logic [`TSD_IR_W-1:0] bs_ir;
   logic [`TSD_IR_W-1:0] ch_ir;
   logic [31:0] ch_dr;
   logic ch_upd;
   logic bs_tdo;
   logic [31:0] ch_cap;
   logic busy;

   // System clock domain
   always_comb begin
      n = r;
      n.rd_en = 1'b0;
      n.wr_en = 1'b0;
      n.sram_we = 1'b0;
      n.boot_go = 1'b0;
      n.prog_done = 1'b0;
      n.prog_rej = 1'b0;
      n.tile_req = 1'b0;
      n.jreq_s1 = jr.req_tgl;
      n.jreq_s2 = r.jreq_s1;
      n.dbg_s1 = debug_n_i;
      n.dbg_s2 = r.dbg_s1;
      pend = (r.jreq_s2 != r.ack_tgl);
      locks = r.sec[`TSD_SEC_LOCK_HI:`TSD_SEC_LOCK_LO];
      n.seen_s1 = jr.sec_seen;
      n.seen_s2 = r.seen_s1;
      // Resource port decode
      go = 1'b0;
      tosec = 1'b0;
      if (res_wr && res_id == `TSD_ID_ADDR) begin
         n.paddr = res_data[15:0];
      end
      if (res_wr && res_id == `TSD_ID_DATA) begin
         n.pdata = res_data;
      end
      if (res_wr && res_id == `TSD_ID_CTRL) begin
         go = res_data[`TSD_CTRL_GO];
         tosec = res_data[`TSD_CTRL_SEC];
      end
      bad = !r.loaded || r.sec[`TSD_SEC_MLOCK];
      if (res_data[`TSD_CTRL_JTAG] && r.sec[`TSD_SEC_NO_JOTP]) begin
         bad = 1'b1;
      end
      if (!tosec) begin
         if (r.paddr[15:`TSD_OTP_AW] != '0 ||
             r.paddr[`TSD_OTP_AW-1:0] == `TSD_OTP_SEC_ROW) begin
            bad = 1'b1;
         end
         if (locks[r.paddr[`TSD_OTP_SECT_HI:`TSD_OTP_SECT_LO]]) begin
            bad = 1'b1;
         end
      end
      if (go) begin
         if (bad) begin
            n.prog_rej = 1'b1;
         end else begin
            n.wr_en = 1'b1;
            n.prog_done = 1'b1;
            if (tosec) begin
               n.wr_addr = `TSD_OTP_SEC_ROW;
               n.wr_data = r.pdata & `TSD_SEC_MASK;
               n.sec = r.sec | (r.pdata & `TSD_SEC_MASK);
               n.sec_tgl = ~r.seen_s2;
            end else begin
               n.wr_addr = r.paddr[`TSD_OTP_AW-1:0];
               n.wr_data = r.pdata;
            end
         end
      end
      case (r.state)
         TSD_IDLE: begin
            n.rd_en = 1'b1;
            n.rd_addr = `TSD_OTP_SEC_ROW;
            n.state = TSD_WSEC;
         end
         TSD_WSEC: begin
            if (otp_rd_valid) begin
               n.sec = r.sec | (otp_rd_data & `TSD_SEC_MASK);
               n.loaded = 1'b1;
               n.sec_tgl = ~r.seen_s2;
               n.ack_tgl = r.jreq_s2;
               n.cnt = '0;
               n.state = TSD_COPY;
            end
         end
         TSD_COPY: begin
            n.rd_en = 1'b1;
            n.rd_addr = r.cnt;
            n.state = TSD_WCOPY;
         end
         TSD_WCOPY: begin
            if (otp_rd_valid) begin
               n.sram_we = 1'b1;
               n.sram_addr = r.cnt;
               n.sram_wdata = otp_rd_data;
               if (r.cnt == `TSD_OTP_LAST_CODE) begin
                  n.boot_go = 1'b1;
                  n.state = TSD_RUN;
               end else begin
                  n.cnt = r.cnt + `TSD_OTP_AW'(1);
                  n.state = TSD_COPY;
               end
            end
         end
         TSD_RUN: begin
            if (pend) begin
               if (jr.jop == `TSD_JOP_OTPRD) begin
                  if (r.sec[`TSD_SEC_NO_JOTP] || r.sec[`TSD_SEC_NO_JTAG]) begin
                     n.jrd_data = 32'h0000_0000;
                     n.ack_tgl = r.jreq_s2;
                  end else begin
                     n.rd_en = 1'b1;
                     n.rd_addr = jr.jword[`TSD_OTP_AW-1:0];
                     n.state = TSD_JRD;
                  end
               end else begin
                  n.tile_req = !r.sec[`TSD_SEC_NO_JTAG];
                  n.tile_data = jr.jword;
                  n.ack_tgl = r.jreq_s2;
               end
            end
         end
         TSD_JRD: begin
            if (otp_rd_valid) begin
               n.jrd_data = otp_rd_data;
               n.ack_tgl = r.jreq_s2;
               n.state = TSD_RUN;
            end
         end
         default: n.state = TSD_IDLE;
      endcase
      // Breakpoint latch, set wins over resume
      n.bp = (r.bp && !dbg_resume) || (bp_hit && dbg_out_mode);
      n.drv = r.bp && dbg_out_mode && r.loaded &&
              !r.sec[`TSD_SEC_NO_DBG];
      n.dbg_enter = dbg_in_mode && !r.dbg_s2 && r.loaded &&
                    !r.sec[`TSD_SEC_NO_DBG];
   end

   always_ff @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         r <= '0;
         r.state <= TSD_IDLE;
         r.sec <= `TSD_SEC_RESET;
         r.dbg_s1 <= 1'b1;
         r.dbg_s2 <= 1'b1;
      end else begin
         r <= n;
      end
   end

   assign otp_rd_en = r.rd_en;
   assign otp_rd_addr = r.rd_addr;
   assign otp_wr_en = r.wr_en;
   assign otp_wr_addr = r.wr_addr;
   assign otp_wr_data = r.wr_data;
   assign otp_redundant_en = r.sec[`TSD_SEC_REDUND];
   assign sram_we = r.sram_we;
   assign sram_addr = r.sram_addr;
   assign sram_wdata = r.sram_wdata;
   assign boot_go = r.boot_go;
   assign boot_from_otp = r.sec[`TSD_SEC_BOOT_OTP];
   assign prog_done = r.prog_done;
   assign prog_reject = r.prog_rej;
   assign security_word = r.sec;
   assign security_loaded = r.loaded;
   assign sw_field = r.sec[`TSD_SEC_SW_HI:`TSD_SEC_SW_LO];
   assign link_grant = link_req && r.loaded &&
                       !r.sec[`TSD_SEC_NO_LINK];
   assign tile_req = r.tile_req;
   assign tile_data = r.tile_data;
   assign debug_n_o = 1'b0;
   assign debug_n_oe = r.drv;
   assign dbg_enter = r.dbg_enter;

   // JTAG clock domain, held in reset by trst_n alone
   always_comb begin
      jn = jr;
      jn.sec_s1 = r.sec_tgl;
      jn.sec_s2 = jr.sec_s1;
      jn.ack_s1 = r.ack_tgl;
      jn.ack_s2 = jr.ack_s1;
      busy = (jr.req_tgl != jr.ack_s2);
      if (jr.sec_s2 != jr.sec_seen) begin
         jn.sec_seen = jr.sec_s2;
         jn.tsec = r.sec;
         jn.tloaded = 1'b1;
      end
      if (ch_upd && jr.tloaded && !busy && !jr.tsec[`TSD_SEC_NO_JTAG]) begin
         if (ch_ir == `TSD_IR_TILE) begin
            jn.jop = `TSD_JOP_TILE;
            jn.jword = ch_dr;
            jn.req_tgl = ~jr.req_tgl;
         end
         if (ch_ir == `TSD_IR_OTPRD && !jr.tsec[`TSD_SEC_NO_JOTP]) begin
            jn.jop = `TSD_JOP_OTPRD;
            jn.jword = ch_dr;
            jn.req_tgl = ~jr.req_tgl;
         end
      end
      case (ch_ir)
         `TSD_IR_JTAG_IDENTIFICATION_WORD: ch_cap = CHIP_JTAG_IDENTIFICATION_WORD;
         `TSD_IR_USERCODE: ch_cap = {jr.tsec[`TSD_SEC_UID_HI:`TSD_SEC_UID_LO],
            `TSD_UNUSED_W'(0), SILICON_REV};
         `TSD_IR_OTPRD: ch_cap = (busy || jr.tsec[`TSD_SEC_NO_JTAG]) ?
            32'h0000_0000 : r.jrd_data;
         default: ch_cap = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         jr <= '0;
      end else begin
         jr <= jn;
      end
   end

   // Boundary scan TAP first in the chain, chip TAP after it
   tsd_tap u_bscan (
      .tck(tck),
      .trst_n(trst_n),
      .tms(tms),
      .tdi(tdi),
      .tdo(bs_tdo),
      .capture_word((bs_ir == `TSD_IR_JTAG_IDENTIFICATION_WORD) ? BSCAN_JTAG_IDENTIFICATION_WORD : 32'h0000_0000),
      .ir(bs_ir),
      .update_dr(),
      .dr_word()
   );

   tsd_tap u_chip (
      .tck(tck),
      .trst_n(trst_n),
      .tms(tms),
      .tdi(bs_tdo),
      .tdo(tdo),
      .capture_word(ch_cap),
      .ir(ch_ir),
      .update_dr(ch_upd),
      .dr_word(ch_dr)
   );
endmodule
`default_nettype wire

// ==== hdl/tsd_defs.svh ====
// Constants of the tile security and debug access block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef TSD_DEFS_SVH
`define TSD_DEFS_SVH

// Security word bit positions
`define TSD_SEC_NO_JTAG 0
`define TSD_SEC_NO_LINK 1
`define TSD_SEC_BOOT_OTP 5
`define TSD_SEC_REDUND 7
`define TSD_SEC_LOCK_LO 8
`define TSD_SEC_LOCK_HI 11
`define TSD_SEC_MLOCK 12
`define TSD_SEC_NO_JOTP 13
`define TSD_SEC_NO_DBG 14
`define TSD_SEC_SW_LO 15
`define TSD_SEC_SW_HI 21
`define TSD_SEC_UID_LO 22
`define TSD_SEC_UID_HI 31
// Bits 2 to 4 and 6 carry no function
`define TSD_SEC_MASK 32'hFFFF_FFA3
`define TSD_SEC_RESET 32'h0000_0000

// OTP geometry
`define TSD_OTP_SECTORS 4
`define TSD_OTP_ROWS 512
`define TSD_OTP_AW 11
`define TSD_OTP_SEC_ROW 11'h7FF
`define TSD_OTP_LAST_CODE 11'h7FE
`define TSD_OTP_SECT_HI 10
`define TSD_OTP_SECT_LO 9

// Programming port resource identifiers
`define TSD_ID_W 24
`define TSD_ID_ADDR 24'h10_0200
`define TSD_ID_DATA 24'h20_0100
`define TSD_ID_CTRL 24'h10_0300
`define TSD_CTRL_GO 0
`define TSD_CTRL_SEC 1
`define TSD_CTRL_JTAG 2

// JTAG instructions
`define TSD_IR_W 4
`define TSD_IR_JTAG_IDENTIFICATION_WORD 4'h1
`define TSD_IR_USERCODE 4'h2
`define TSD_IR_OTPRD 4'h3
`define TSD_IR_TILE 4'h4
`define TSD_IR_BYPASS 4'hF
`define TSD_IR_CAPTURE 4'h1
`define TSD_UNUSED_W 4
`define TSD_REV_W 18

// Requests crossing from the JTAG side
`define TSD_JOP_TILE 1'b0
`define TSD_JOP_OTPRD 1'b1

`endif

// ==== hdl/tsd_pkg.sv ====
// Types of the tile security and debug access block.
// Assumes tsd_defs.svh on the include path.
`default_nettype none
`include "tsd_defs.svh"
package tsd_pkg;

   typedef enum logic [2:0] {
      TSD_IDLE  = 3'h0,
      TSD_WSEC  = 3'h1,
      TSD_COPY  = 3'h3,
      TSD_WCOPY = 3'h2,
      TSD_RUN   = 3'h6,
      TSD_JRD   = 3'h7
   } tsd_sys_e;

   typedef enum logic [3:0] {
      TSD_TLR   = 4'h0,
      TSD_RTI   = 4'h1,
      TSD_SELDR = 4'h3,
      TSD_CAPDR = 4'h2,
      TSD_SHDR  = 4'h6,
      TSD_EX1DR = 4'h7,
      TSD_PDR   = 4'h5,
      TSD_EX2DR = 4'h4,
      TSD_UPDR  = 4'hC,
      TSD_SELIR = 4'hD,
      TSD_CAPIR = 4'hF,
      TSD_SHIR  = 4'hE,
      TSD_EX1IR = 4'hA,
      TSD_PIR   = 4'hB,
      TSD_EX2IR = 4'h9,
      TSD_UPIR  = 4'h8
   } tsd_tap_e;

   typedef struct packed {
      tsd_tap_e st;
      logic [`TSD_IR_W-1:0] ir;
      logic [`TSD_IR_W-1:0] irsh;
      logic [31:0] dr;
   } tsd_tap_s;

   typedef struct packed {
      tsd_sys_e state;
      logic [31:0] sec;
      logic loaded;
      logic sec_tgl;
      logic seen_s1;
      logic seen_s2;
      logic [`TSD_OTP_AW-1:0] cnt;
      logic rd_en;
      logic [`TSD_OTP_AW-1:0] rd_addr;
      logic wr_en;
      logic [`TSD_OTP_AW-1:0] wr_addr;
      logic [31:0] wr_data;
      logic sram_we;
      logic [`TSD_OTP_AW-1:0] sram_addr;
      logic [31:0] sram_wdata;
      logic boot_go;
      logic [15:0] paddr;
      logic [31:0] pdata;
      logic prog_done;
      logic prog_rej;
      logic jreq_s1;
      logic jreq_s2;
      logic ack_tgl;
      logic [31:0] jrd_data;
      logic tile_req;
      logic [31:0] tile_data;
      logic dbg_s1;
      logic dbg_s2;
      logic bp;
      logic drv;
      logic dbg_enter;
   } tsd_sys_s;

   typedef struct packed {
      logic sec_s1;
      logic sec_s2;
      logic sec_seen;
      logic [31:0] tsec;
      logic tloaded;
      logic ack_s1;
      logic ack_s2;
      logic req_tgl;
      logic jop;
      logic [31:0] jword;
   } tsd_jtg_s;

endpackage
`default_nettype wire

// ==== hdl/tsd_tap.sv ====
// One JTAG test access port controller with IR and a 32-bit DR.
// Assumes tck and trst_n from the JTAG pins; DR content given by parent.
`default_nettype none
`include "tsd_defs.svh"
module tsd_tap
   import tsd_pkg::*;
(
   // JTAG
   input wire logic tck,
   input wire logic trst_n,
   input wire logic tms,
   input wire logic tdi,
   output logic tdo,
   // Data register side
   input wire logic [31:0] capture_word,
   output logic [`TSD_IR_W-1:0] ir,
   output logic update_dr,
   output logic [31:0] dr_word
);
   tsd_tap_s r;
   tsd_tap_s n;
   logic byp;

   always_comb begin
      n = r;
      byp = (r.ir == `TSD_IR_BYPASS);
      case (r.st)
         TSD_TLR: n.st = tms ? TSD_TLR : TSD_RTI;
         TSD_RTI: n.st = tms ? TSD_SELDR : TSD_RTI;
         TSD_SELDR: n.st = tms ? TSD_SELIR : TSD_CAPDR;
         TSD_CAPDR: n.st = tms ? TSD_EX1DR : TSD_SHDR;
         TSD_SHDR: n.st = tms ? TSD_EX1DR : TSD_SHDR;
         TSD_EX1DR: n.st = tms ? TSD_UPDR : TSD_PDR;
         TSD_PDR: n.st = tms ? TSD_EX2DR : TSD_PDR;
         TSD_EX2DR: n.st = tms ? TSD_UPDR : TSD_SHDR;
         TSD_UPDR: n.st = tms ? TSD_SELDR : TSD_RTI;
         TSD_SELIR: n.st = tms ? TSD_TLR : TSD_CAPIR;
         TSD_CAPIR: n.st = tms ? TSD_EX1IR : TSD_SHIR;
         TSD_SHIR: n.st = tms ? TSD_EX1IR : TSD_SHIR;
         TSD_EX1IR: n.st = tms ? TSD_UPIR : TSD_PIR;
         TSD_PIR: n.st = tms ? TSD_EX2IR : TSD_PIR;
         TSD_EX2IR: n.st = tms ? TSD_UPIR : TSD_SHIR;
         TSD_UPIR: n.st = tms ? TSD_SELDR : TSD_RTI;
         default: n.st = TSD_TLR;
      endcase
      case (r.st)
         TSD_TLR: n.ir = `TSD_IR_JTAG_IDENTIFICATION_WORD;
         TSD_CAPDR: n.dr = byp ? 32'h0000_0000 : capture_word;
         TSD_SHDR: begin
            if (byp) begin
               n.dr = {31'h0000_0000, tdi};
            end else begin
               n.dr = {tdi, r.dr[31:1]};
            end
         end
         TSD_CAPIR: n.irsh = `TSD_IR_CAPTURE;
         TSD_SHIR: n.irsh = {tdi, r.irsh[`TSD_IR_W-1:1]};
         TSD_UPIR: n.ir = r.irsh;
         default: n.dr = r.dr;
      endcase
   end

   always_ff @(posedge tck or negedge trst_n) begin
      if (!trst_n) begin
         r.st <= TSD_TLR;
         r.ir <= `TSD_IR_JTAG_IDENTIFICATION_WORD;
         r.irsh <= `TSD_IR_CAPTURE;
         r.dr <= 32'h0000_0000;
      end else begin
         r <= n;
      end
   end

   assign tdo = (r.st == TSD_SHDR) ? r.dr[0] :
                (r.st == TSD_SHIR) ? r.irsh[0] : 1'b0;
   assign ir = r.ir;
   assign update_dr = (r.st == TSD_UPDR);
   assign dr_word = r.dr;
endmodule
`default_nettype wire

// ==== tb/tsd_otp_model.sv ====
// OTP array model answering the loader and taking programmed rows.
// Assumes one read in flight; lat sets the read latency in cycles.
`default_nettype none
module tsd_otp_model (
   // System
   input wire logic sys_clk,
   input wire logic [3:0] lat,
   // Read port
   input wire logic rd_en,
   input wire logic [10:0] rd_addr,
   output logic rd_valid,
   output logic [31:0] rd_data,
   // Program port
   input wire logic wr_en,
   input wire logic [10:0] wr_addr,
   input wire logic [31:0] wr_data
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [31:0] mem [0:2047]; // Four sectors of 512 rows
   logic [10:0] a;
   int cnt = 0;
   initial begin
      rd_valid = 1'b0;
      rd_data = 32'h0000_0000;
      for (int i = 0; i < 2048; i++) mem[i] = 32'hC3C3_0000 | i;
      mem[2047] = 32'h0000_0000;
   end
   always @(posedge sys_clk) begin
      rd_valid <= 1'b0;
      rd_data <= ~rd_data; // Word inverted every cycle outside a valid cycle
      if (wr_en) mem[wr_addr] <= mem[wr_addr] | wr_data;
      if (rd_en) begin
         a <= rd_addr;
         cnt <= lat;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end else if (cnt == 1) begin
         cnt <= 0;
         rd_valid <= 1'b1;
         rd_data <= mem[a];
      end
   end
endmodule
`default_nettype wire

// ==== tb/tsd_top_checker.sv ====
// Port checker of the tile security block.
// Assumes binding into tsd_top; rules checked in the sys_clk domain.
`default_nettype none
`include "tsd_defs.svh"
module tsd_top_checker (
   // Clocks and resets
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic tck,
   input wire logic trst_n,
   // Programming
   input wire logic res_wr,
   input wire logic [`TSD_ID_W-1:0] res_id,
   input wire logic [31:0] res_data,
   input wire logic prog_done,
   input wire logic prog_reject,
   // Security state
   input wire logic [31:0] security_word,
   input wire logic security_loaded,
   input wire logic [`TSD_SEC_SW_HI-`TSD_SEC_SW_LO:0] sw_field,
   input wire logic boot_from_otp,
   input wire logic otp_redundant_en,
   input wire logic link_req,
   input wire logic link_grant,
   // Debug pin
   input wire logic dbg_out_mode,
   input wire logic bp_hit,
   input wire logic debug_n_o,
   input wire logic debug_n_oe,
   input wire logic dbg_enter
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] last_addr;
   logic go;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   assign go = res_wr && res_id == `TSD_ID_CTRL && res_data[`TSD_CTRL_GO];
   always_ff @(posedge sys_clk or posedge sys_rst)
      if (sys_rst) last_addr <= 16'h0000;
      else if (res_wr && res_id == `TSD_ID_ADDR) last_addr <= res_data[15:0];
   a_link_deny: assert property (
      link_grant |-> link_req && security_loaded && !security_word[1])
      else $error("link granted while denied");
   a_early_block: assert property (
      !security_loaded |-> !link_grant && !prog_done)
      else $error("access before security word load");
   a_boot_src: assert property (
      security_loaded && $stable(security_word) |->
      boot_from_otp == security_word[5])
      else $error("boot source differs from bit 5");
   a_redund_en: assert property (
      security_loaded && $stable(security_word) |->
      otp_redundant_en == security_word[7])
      else $error("redundant enable differs from bit 7");
   a_soft_field: assert property (
      $stable(security_word) |-> sw_field == security_word[21:15])
      else $error("software field mismatch");
   a_dead_bits: assert property (
      (security_word[6:2] & 5'h17) == 5'h00)
      else $error("unused security bits set");
   a_sticky_bits: assert property (
      security_loaded |=>
      (security_word & $past(security_word)) == $past(security_word))
      else $error("security bit cleared");
   a_master_lock: assert property (
      go && security_word[12] |=> prog_reject && !prog_done)
      else $error("programming passed master lock");
   a_jtag_otp: assert property (
      go && res_data[`TSD_CTRL_JTAG] && security_word[13] |=> prog_reject)
      else $error("jtag programming passed");
   a_sector_lock: assert property (
      go && !res_data[`TSD_CTRL_SEC] && last_addr < 16'h07FF &&
      security_word[`TSD_SEC_LOCK_LO + last_addr[10:9]] |=> prog_reject)
      else $error("locked sector programmed");
   a_prog_once: assert property (
      go |=> prog_done != prog_reject)
      else $error("programming answer missing or doubled");
   a_dbg_quiet: assert property (
      security_word[14] && $past(security_word[14]) |->
      !debug_n_oe && !dbg_enter)
      else $error("debug pin active while disabled");
   a_dbg_drive: assert property (
      dbg_out_mode && bp_hit && security_loaded && !security_word[14]
      |-> ##2 debug_n_oe && !debug_n_o)
      else $error("debug pin not driven low after breakpoint");
endmodule
bind tsd_top tsd_top_checker chk_u (.sys_clk, .sys_rst, .tck, .trst_n,
   .res_wr, .res_id, .res_data, .prog_done, .prog_reject, .security_word,
   .security_loaded, .sw_field, .boot_from_otp, .otp_redundant_en,
   .link_req, .link_grant, .dbg_out_mode, .bp_hit, .debug_n_o,
   .debug_n_oe, .dbg_enter);
`default_nettype wire

// ==== tb/tsd_top_tb.sv ====
// Bench for the tile security block: OTP model, JTAG host, resource ports.
// Assumes the package, design, OTP model and checker compiled first.
`default_nettype none
`include "tsd_defs.svh"
module tsd_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   // Identity values are arbitrary
   localparam logic [31:0] CID = 32'h0ABC_1001;
   localparam logic [31:0] BID = 32'h0ABC_2001;
   localparam logic [17:0] REV = 18'h0_0005;
   localparam logic [31:0] V1 = 32'h8041_C920;
   logic sys_clk, sys_rst, otp_rd_en, otp_rd_valid, otp_wr_en;
   logic otp_redundant_en, sram_we, boot_go, boot_from_otp, res_wr;
   logic prog_done, prog_reject, security_loaded, link_req, link_grant;
   logic tile_req, dbg_out_mode, dbg_in_mode, bp_hit, dbg_resume;
   logic debug_n_o, debug_n_oe, dbg_enter, tck, trst_n, tms, tdi, tdo;
   logic ext_n, jo;
   logic [10:0] otp_rd_addr, otp_wr_addr, sram_addr;
   logic [31:0] otp_rd_data, otp_wr_data, sram_wdata, res_data;
   logic [31:0] security_word, tile_data, t_word;
   logic [23:0] res_id;
   logic [6:0] sw_field;
   logic [3:0] lat;
   logic [63:0] q;
   logic [15:0] ra [4] = '{16'h0005, 16'h0205, 16'h0600, 16'h07FF};
   logic rj [4] = '{1'b1, 1'b0, 1'b1, 1'b1};
   wire dbg_pin;
   int n_errors = 0, total_checks = 0, n_rows = 0, n_boot = 0, n_tile = 0;
   tsd_top #(.CHIP_JTAG_IDENTIFICATION_WORD(CID), .BSCAN_JTAG_IDENTIFICATION_WORD(BID), .SILICON_REV(REV))
   dut_u (.sys_clk, .sys_rst, .otp_rd_en, .otp_rd_addr, .otp_rd_valid,
      .otp_rd_data, .otp_wr_en, .otp_wr_addr, .otp_wr_data,
      .otp_redundant_en, .sram_we, .sram_addr, .sram_wdata, .boot_go,
      .boot_from_otp, .res_wr, .res_id, .res_data, .prog_done,
      .prog_reject, .security_word, .security_loaded, .sw_field,
      .link_req, .link_grant, .tile_req, .tile_data, .dbg_out_mode,
      .dbg_in_mode, .bp_hit, .dbg_resume, .debug_n_i(dbg_pin),
      .debug_n_o, .debug_n_oe, .dbg_enter, .tck, .trst_n, .tms, .tdi,
      .tdo);
   tsd_otp_model otp_u (.sys_clk, .lat, .rd_en(otp_rd_en),
      .rd_addr(otp_rd_addr), .rd_valid(otp_rd_valid),
      .rd_data(otp_rd_data), .wr_en(otp_wr_en), .wr_addr(otp_wr_addr),
      .wr_data(otp_wr_data));
   // Pulled-up pin, low when either side drives it
   assign dbg_pin = (debug_n_oe ? debug_n_o : 1'b1) & ext_n;
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   always @(negedge sys_clk) begin
      if (sram_we) begin
         chk(sram_wdata, 32'hC3C3_0000 | sram_addr);
         n_rows++;
      end
      if (boot_go) n_boot++;
      if (tile_req) begin
         n_tile++;
         t_word = tile_data;
      end
   end
   task automatic boot(input logic [31:0] sec, input logic [3:0] l);
      int nb;
      nb = n_boot;
      sys_rst = 1'b1;
      lat = l;
      n_rows = 0;
      repeat (5) @(negedge sys_clk);
      otp_u.mem[11'h7FF] = otp_u.mem[11'h7FF] | sec;
      sys_rst = 1'b0;
      for (int i = 0; i < 30000 && n_boot == nb; i++) @(negedge sys_clk);
      repeat (3) @(negedge sys_clk);
      chk(n_rows, 2047);
      chk(security_loaded, 1'b1);
   endtask
   task automatic wres(input logic [23:0] id, input logic [31:0] d);
      @(negedge sys_clk);
      res_wr = 1'b1;
      res_id = id;
      res_data = d;
   endtask
   task automatic prog(input logic [15:0] a, input logic [31:0] d,
         input logic [2:0] c, input logic rej);
      wres(`TSD_ID_ADDR, {16'h0000, a});
      wres(`TSD_ID_DATA, d);
      wres(`TSD_ID_CTRL, {29'h0, c});
      @(negedge sys_clk);
      res_wr = 1'b0;
      chk({prog_done, prog_reject}, {!rej, rej});
      if (!rej && !c[1]) begin
         chk(otp_wr_addr, a[10:0]);
         chk(otp_wr_data, d);
      end
   endtask
   task automatic jb(input logic m, input logic d);
      tms = m;
      tdi = d;
      #15 jo = tdo;
      tck = 1'b1;
      #15 tck = 1'b0;
   endtask
   task automatic jir(input logic [7:0] ir);
      jb(1, 0); jb(1, 0); jb(0, 0); jb(0, 0);
      for (int i = 0; i < 8; i++) jb(i == 7, ir[i]);
      jb(1, 0); jb(0, 0);
   endtask
   task automatic jdr(input logic [63:0] din, input int n);
      q = 64'h0;
      jb(1, 0); jb(0, 0); jb(0, 0);
      for (int i = 0; i < n; i++) begin
         jb(i == n - 1, din[i]);
         q[i] = jo;
      end
      jb(1, 0); jb(0, 0);
      @(negedge sys_clk);
   endtask
   task automatic user(input logic [9:0] uid);
      jir({4'hF, `TSD_IR_USERCODE});
      jdr(64'h0, 33);
      chk(q[31:0], {uid, 4'h0, REV});
   endtask
   task automatic tile(input int exp);
      n_tile = 0;
      jir({4'hF, `TSD_IR_TILE});
      jdr(64'h5A5A_1234, 33);
      repeat (12) @(negedge sys_clk);
      chk(n_tile, exp);
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // Three boots of about 10k cycles each plus JTAG frames fit well inside
   initial begin
      #1_500_000;
      n_errors++;
      close_out();
   end
   initial begin
      {sys_rst, trst_n, tck, tms, tdi, res_wr, link_req} = 7'b1000001;
      {dbg_out_mode, dbg_in_mode, bp_hit, dbg_resume, ext_n} = 5'b00001;
      res_id = 24'h0;
      res_data = 32'h0;
      lat = 4'h1;
      boot(32'h0, 4'h1);
      #100 trst_n = 1'b1;
      jb(0, 0);
      jdr(64'h0, 64);
      chk(q[31:0], CID);
      chk(q[63:32], BID);
      user(10'h000);
      tile(1);
      chk(t_word, 32'h5A5A_1234);
      jir({4'hF, `TSD_IR_OTPRD});
      jdr(64'h0010, 33);
      repeat (12) @(negedge sys_clk);
      jdr(64'h0, 33);
      chk(q[31:0], 32'hC3C3_0010);
      chk(link_grant, 1'b1);
      dbg_out_mode = 1'b1;
      bp_hit = 1'b1;
      @(negedge sys_clk) bp_hit = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk({debug_n_oe, dbg_pin}, 2'b10);
      dbg_resume = 1'b1;
      @(negedge sys_clk) dbg_resume = 1'b0;
      repeat (3) @(negedge sys_clk);
      chk(debug_n_oe, 1'b0);
      dbg_in_mode = 1'b1;
      ext_n = 1'b0;
      repeat (6) @(negedge sys_clk);
      chk(dbg_enter, 1'b1);
      prog(16'h0010, 32'hC3C3_0010, 3'h1, 1'b0);
      prog(16'h0000, 32'h8041_C97C, 3'h3, 1'b0);
      chk(security_word, V1);
      chk(sw_field, 7'h03);
      @(negedge sys_clk);
      chk({boot_from_otp, otp_redundant_en}, 2'b10);
      for (int i = 0; i < 4; i++)
         prog(ra[i], 32'hC3C3_0000 | ra[i], 3'h1, rj[i]);
      bp_hit = 1'b1;
      @(negedge sys_clk) bp_hit = 1'b0;
      repeat (4) @(negedge sys_clk);
      chk({debug_n_oe, dbg_enter}, 2'b00);
      ext_n = 1'b1;
      $display("test one done");
      boot(32'h0, 4'h3);
      chk(security_word, V1);
      chk(boot_from_otp, 1'b1);
      user(10'h201);
      $display("test two done");
      boot(32'h0000_2083, 4'h1);
      chk(security_word, V1 | 32'h0000_2083);
      chk({link_grant, otp_redundant_en}, 2'b01);
      tile(0);
      prog(16'h0206, 32'hC3C3_0206, 3'h1, 1'b0);
      prog(16'h0205, 32'hC3C3_0205, 3'h5, 1'b1);
      prog(16'h0000, 32'h0000_1000, 3'h3, 1'b0);
      prog(16'h0206, 32'hC3C3_0206, 3'h1, 1'b1);
      prog(16'h0000, 32'h0000_0001, 3'h3, 1'b1);
      $display("test three done");
      close_out();
   end
endmodule
`default_nettype wire
